// *** shared/ros_pkg.sv ***
// Constants, enumerations and the state record of the regulator on/off sequencer.
package ros_pkg;

  localparam int unsigned NUM_RAILS   = 7;
  localparam int unsigned CLK_MHZ     = 40;

  // Slot spacing and reset base delay in microseconds, as printed, and cycles derived from the 40 MHz clock.
  localparam int unsigned STEP_FAST_US  = 500;
  localparam int unsigned STEP_SLOW_US  = 2000;
  localparam int unsigned STEP_DOWN_US  = 2000;
  localparam int unsigned RST_BASE_US   = 2000;
  localparam int unsigned STEP_FAST_CYC = STEP_FAST_US * CLK_MHZ;
  localparam int unsigned STEP_SLOW_CYC = STEP_SLOW_US * CLK_MHZ;
  localparam int unsigned STEP_DOWN_CYC = STEP_DOWN_US * CLK_MHZ;
  localparam int unsigned RST_BASE_CYC  = RST_BASE_US * CLK_MHZ;

  // Reset release delay multipliers of the base delay, 2 ms up to 1024 ms.
  localparam logic [9:0] RST_MULT [8] = '{10'h001, 10'h002, 10'h004, 10'h008,
                                          10'h010, 10'h020, 10'h040, 10'h200};

  // Register byte addresses.
  localparam logic [7:0] ADDR_OFF_BASE = 8'h00;
  localparam logic [7:0] ADDR_ON_SLOTS = 8'h1C;
  localparam logic [7:0] ADDR_STATUS   = 8'h20;
  localparam logic [7:0] ADDR_MASK     = 8'h24;
  localparam logic [7:0] ADDR_STATE    = 8'h28;

  // Status and mask bit positions, and the mask reset value.
  localparam int unsigned BIT_PWRUP = 0;
  localparam int unsigned BIT_PWRDN = 1;
  localparam logic [1:0]  MASK_RESET = 2'h0;

  typedef enum logic [2:0] {
    K_DIS_RUN   = 3'h0,
    K_STBY_RUN  = 3'h1,
    K_SLEEP_RUN = 3'h2,
    K_RUN_STBY  = 3'h3,
    K_RUN_SLEEP = 3'h4,
    K_RUN_DIS   = 3'h5
  } ros_kind_e;

  typedef enum logic [2:0] {
    S_IDLE    = 3'h0,
    S_UP      = 3'h1,
    S_UP_WAIT = 3'h3,
    S_RST     = 3'h2,
    S_DN      = 3'h6,
    S_DN_WAIT = 3'h7
  } ros_state_e;

  typedef struct packed {
    ros_state_e       st;
    ros_kind_e        kind;
    logic [2:0]       slot;
    logic [31:0]      cnt;
    logic [6:0]       work;
    logic [6:0]       rail_en;
    logic             rtc_en;
    logic             cpu_rst_n;
    logic [6:0][2:0]  off_slot;
    logic             loaded;
    logic             sys_on;
    logic [1:0]       status;
    logic [1:0]       mask;
    logic             irq;
    logic             done;
    logic             busy;
    logic [31:0]      rd_data;
  } ros_regs_t;

endpackage

// *** rtl/ros_sequencer.sv ***
// Regulator on/off sequencer with register port and interrupt.
`timescale 1ns/10ps

module ros_sequencer #(
  parameter int unsigned STEP_FAST_CYC = ros_pkg::STEP_FAST_CYC,
  parameter int unsigned STEP_SLOW_CYC = ros_pkg::STEP_SLOW_CYC,
  parameter int unsigned STEP_DOWN_CYC = ros_pkg::STEP_DOWN_CYC,
  parameter int unsigned RST_BASE_CYC  = ros_pkg::RST_BASE_CYC
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic [6:0][2:0]  reg_on_slot,
  input  wire logic [2:0]       reset_release_delay_sel,
  input  wire logic             seq_step_speed,
  input  wire logic             req_valid,
  input  wire logic [2:0]       req_kind,
  input  wire logic [6:0]       req_target,
  input  wire logic [7:0]       bus_addr,
  input  wire logic [31:0]      bus_wdata,
  input  wire logic             bus_write,
  input  wire logic             bus_read,
  output logic      [31:0]      bus_rdata,
  output logic      [6:0]       rail_en,
  output logic                  rtc_supply_rail,
  output logic                  processor_reset_out_n,
  output logic                  seq_busy,
  output logic                  trans_done,
  output logic                  irq
);

  ros_pkg::ros_regs_t r_reg;
  ros_pkg::ros_regs_t r_next;

  logic [6:0] on_hit;
  logic [6:0] on_above;
  logic [6:0] off_hit;
  logic [6:0] off_below;
  logic       off_all_zero;
  logic [31:0] step_up_cyc;
  logic [31:0] rst_cyc;

  // Per-rail slot comparisons against the slot being stepped.
  genvar gi;
  generate
    for (gi = 0; gi < ros_pkg::NUM_RAILS; gi++) begin : g_rail
      assign on_hit[gi]    = (reg_on_slot[gi] == r_reg.slot);
      assign on_above[gi]  = (reg_on_slot[gi] > r_reg.slot);
      assign off_hit[gi]   = (r_reg.off_slot[gi] == r_reg.slot);
      assign off_below[gi] = (r_reg.off_slot[gi] < r_reg.slot);
    end
  endgenerate

  assign off_all_zero = (r_reg.off_slot == '0);
  assign step_up_cyc  = seq_step_speed ? 32'(STEP_SLOW_CYC) : 32'(STEP_FAST_CYC);
  assign rst_cyc      = 32'(RST_BASE_CYC * ros_pkg::RST_MULT[reset_release_delay_sel]);

  always_comb begin
    logic       wr_ok;
    logic [6:0] hit;
    logic [6:0] rest;
    logic [1:0] ev;
    logic [3:0] idx;
    r_next = r_reg;
    wr_ok  = 1'b0;
    hit    = '0;
    rest   = '0;
    ev     = '0;
    idx    = bus_addr[5:2];
    r_next.done = 1'b0;

    case (r_reg.st)
      ros_pkg::S_IDLE: begin
        if (!r_reg.loaded) begin
          r_next.off_slot = reg_on_slot;
          r_next.loaded   = 1'b1;
          r_next.rtc_en   = 1'b1;
        end else if (req_valid) begin
          r_next.kind = ros_pkg::ros_kind_e'(req_kind);
          case (req_kind)
            ros_pkg::K_DIS_RUN, ros_pkg::K_STBY_RUN, ros_pkg::K_SLEEP_RUN: begin
              r_next.work = req_target & ~r_reg.rail_en;
              r_next.slot = 3'h0;
              if (req_kind == ros_pkg::K_STBY_RUN && r_next.work == '0) begin
                ev[ros_pkg::BIT_PWRUP] = 1'b1;
                r_next.done = 1'b1;
              end else begin
                r_next.st = ros_pkg::S_UP;
              end
            end
            ros_pkg::K_RUN_STBY, ros_pkg::K_RUN_SLEEP, ros_pkg::K_RUN_DIS: begin
              r_next.work = r_reg.rail_en & ~req_target;
              r_next.slot = 3'h7;
              if (req_kind == ros_pkg::K_RUN_DIS) begin
                r_next.cpu_rst_n = 1'b0;
                r_next.sys_on    = 1'b0;
              end
              if (off_all_zero || (req_kind == ros_pkg::K_RUN_STBY && r_next.work == '0)) begin
                r_next.rail_en = r_reg.rail_en & req_target;
                ev[ros_pkg::BIT_PWRDN] = (req_kind != ros_pkg::K_RUN_DIS);
                r_next.done = 1'b1;
              end else begin
                r_next.st = ros_pkg::S_DN;
              end
            end
            default: begin
              r_next.kind = r_reg.kind;
            end
          endcase
        end
      end
      ros_pkg::S_UP: begin
        hit  = r_reg.work & on_hit;
        rest = r_reg.work & on_above;
        r_next.rail_en = r_reg.rail_en | hit;
        r_next.work    = rest;
        r_next.slot    = r_reg.slot + 3'h1;
        if (rest == '0) begin
          if (r_reg.kind == ros_pkg::K_DIS_RUN) begin
            r_next.st  = ros_pkg::S_RST;
            r_next.cnt = rst_cyc - 32'h1;
          end else begin
            r_next.st  = ros_pkg::S_IDLE;
            ev[ros_pkg::BIT_PWRUP] = 1'b1;
            r_next.done = 1'b1;
          end
        end else if (hit != '0) begin
          r_next.st  = ros_pkg::S_UP_WAIT;
          r_next.cnt = step_up_cyc - 32'h1;
        end
      end
      ros_pkg::S_UP_WAIT: begin
        r_next.cnt = r_reg.cnt - 32'h1;
        if (r_reg.cnt == '0) begin
          r_next.st = ros_pkg::S_UP;
        end
      end
      ros_pkg::S_RST: begin
        r_next.cnt = r_reg.cnt - 32'h1;
        if (r_reg.cnt == '0) begin
          r_next.cpu_rst_n = 1'b1;
          r_next.sys_on    = 1'b1;
          r_next.st        = ros_pkg::S_IDLE;
          r_next.done      = 1'b1;
        end
      end
      ros_pkg::S_DN: begin
        hit  = r_reg.work & off_hit;
        rest = r_reg.work & off_below;
        r_next.rail_en = r_reg.rail_en & ~hit;
        r_next.work    = rest;
        r_next.slot    = r_reg.slot - 3'h1;
        if (rest == '0) begin
          r_next.st = ros_pkg::S_IDLE;
          ev[ros_pkg::BIT_PWRDN] = (r_reg.kind != ros_pkg::K_RUN_DIS);
          r_next.done = 1'b1;
        end else if (hit != '0) begin
          r_next.st  = ros_pkg::S_DN_WAIT;
          r_next.cnt = 32'(STEP_DOWN_CYC) - 32'h1;
        end
      end
      ros_pkg::S_DN_WAIT: begin
        r_next.cnt = r_reg.cnt - 32'h1;
        if (r_reg.cnt == '0) begin
          r_next.st = ros_pkg::S_DN;
        end
      end
      default: begin
        r_next.st = ros_pkg::S_IDLE;
      end
    endcase

    // Register writes; a write to a status bit that is set in the same cycle loses.
    if (bus_write) begin
      if (bus_addr < ros_pkg::ADDR_ON_SLOTS && bus_addr[1:0] == 2'h0) begin
        // off slots writable only while on
        wr_ok = r_reg.sys_on && r_reg.st == ros_pkg::S_IDLE;
        if (wr_ok) begin
          r_next.off_slot[idx[2:0]] = bus_wdata[2:0];
        end
      end else if (bus_addr == ros_pkg::ADDR_STATUS) begin
        r_next.status = r_reg.status & ~bus_wdata[1:0];
      end else if (bus_addr == ros_pkg::ADDR_MASK) begin
        r_next.mask = bus_wdata[1:0];
      end
    end
    r_next.status = r_next.status | ev;
    r_next.irq    = |(r_next.status & r_next.mask);
    // Busy is registered so that the output comes straight from a flip-flop.
    r_next.busy   = (r_next.st != ros_pkg::S_IDLE) || !r_next.loaded;

    // Read data stands only in the cycle after the read strobe.
    r_next.rd_data = '0;
    if (bus_read) begin
      if (bus_addr < ros_pkg::ADDR_ON_SLOTS && bus_addr[1:0] == 2'h0) begin
        r_next.rd_data = {29'h0, r_reg.off_slot[idx[2:0]]};
      end else if (bus_addr == ros_pkg::ADDR_ON_SLOTS) begin
        r_next.rd_data = {11'h0, reg_on_slot};
      end else if (bus_addr == ros_pkg::ADDR_STATUS) begin
        r_next.rd_data = {30'h0, r_reg.status};
      end else if (bus_addr == ros_pkg::ADDR_MASK) begin
        r_next.rd_data = {30'h0, r_reg.mask};
      end else if (bus_addr == ros_pkg::ADDR_STATE) begin
        r_next.rd_data = {16'h0, r_reg.sys_on, r_reg.cpu_rst_n, r_reg.rtc_en,
                          r_reg.st, r_reg.slot, r_reg.rail_en};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      r_reg           <= '0;
      r_reg.st        <= ros_pkg::S_IDLE;
      r_reg.kind      <= ros_pkg::K_DIS_RUN;
      r_reg.mask      <= ros_pkg::MASK_RESET;
      r_reg.cpu_rst_n <= 1'b0;
      r_reg.busy      <= 1'b1;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  assign bus_rdata             = r_reg.rd_data;
  assign rail_en               = r_reg.rail_en;
  assign rtc_supply_rail       = r_reg.rtc_en;
  assign processor_reset_out_n = r_reg.cpu_rst_n;
  assign seq_busy              = r_reg.busy;
  assign trans_done            = r_reg.done;
  assign irq                   = r_reg.irq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  a_rtc_first_rail: assert property ((r_reg.rail_en != '0) |-> r_reg.rtc_en)
    else $error("rail enabled before rtc rail");

  a_up_slot_order: assert property (
    (clk_en && r_reg.st == ros_pkg::S_UP) |=> ((r_reg.rail_en & ~$past(r_reg.rail_en)
      & ~$past(on_hit)) == '0))
    else $error("rail enabled outside its on slot");

  a_reset_held_low: assert property (
    (r_reg.st == ros_pkg::S_UP && r_reg.kind == ros_pkg::K_DIS_RUN) |-> !r_reg.cpu_rst_n)
    else $error("processor reset released during power-up");

  a_reset_release_time: assert property (
    $rose(r_reg.cpu_rst_n) |-> ($past(r_reg.st) == ros_pkg::S_RST && $past(r_reg.cnt) == '0))
    else $error("processor reset released early");

  a_stby_skip_seq: assert property (
    (clk_en && r_reg.st == ros_pkg::S_IDLE && r_reg.loaded && req_valid
      && req_kind == ros_pkg::K_STBY_RUN && (req_target & ~r_reg.rail_en) == '0)
    |=> (r_reg.st == ros_pkg::S_IDLE && r_reg.status[ros_pkg::BIT_PWRUP] && r_reg.done))
    else $error("standby to run without rails did not finish at once");

  a_up_done_flag: assert property (
    (clk_en && r_reg.st == ros_pkg::S_UP && r_reg.kind != ros_pkg::K_DIS_RUN
      && (r_reg.work & on_above) == '0) |=> r_reg.status[ros_pkg::BIT_PWRUP])
    else $error("power-up done flag not set");

  a_dn_slot_order: assert property (
    (clk_en && r_reg.st == ros_pkg::S_DN) |=> ((~r_reg.rail_en & $past(r_reg.rail_en)
      & ~$past(off_hit)) == '0))
    else $error("rail dropped outside its off slot");

  a_bypass_all_off: assert property (
    (clk_en && r_reg.st == ros_pkg::S_IDLE && r_reg.loaded && req_valid && off_all_zero
      && req_kind inside {ros_pkg::K_RUN_STBY, ros_pkg::K_RUN_SLEEP})
    |=> (r_reg.st == ros_pkg::S_IDLE && (r_reg.rail_en & ~$past(req_target)) == '0
         && r_reg.status[ros_pkg::BIT_PWRDN]))
    else $error("all-zero off slots did not drop rails at once");

  a_dn_flag_end: assert property (
    (clk_en && r_reg.st == ros_pkg::S_DN && r_reg.kind != ros_pkg::K_RUN_DIS
      && (r_reg.work & off_below) == '0) |=> r_reg.status[ros_pkg::BIT_PWRDN])
    else $error("power-down flag not set");

  a_dn_step_wait: assert property (
    (clk_en && r_reg.st == ros_pkg::S_DN && $past(r_reg.st) == ros_pkg::S_DN_WAIT)
    |-> ($past(r_reg.cnt) == '0))
    else $error("power-down step taken early");

  a_up_step_wait: assert property (
    (r_reg.st == ros_pkg::S_UP && $past(r_reg.st) == ros_pkg::S_UP_WAIT) |-> ($past(r_reg.cnt) == '0))
    else $error("power-up step taken early");

  a_up_wait_len: assert property ((r_reg.st == ros_pkg::S_UP_WAIT) |-> (r_reg.cnt < step_up_cyc))
    else $error("power-up wait longer than spacing");

  a_dn_wait_len: assert property (
    (r_reg.st == ros_pkg::S_DN_WAIT) |-> (r_reg.cnt < 32'(STEP_DOWN_CYC)))
    else $error("power-down wait longer than spacing");

  a_rst_wait_len: assert property ((r_reg.st == ros_pkg::S_RST) |-> (r_reg.cnt < rst_cyc))
    else $error("reset delay longer than selected");

  a_rst_low_wait: assert property ((r_reg.st == ros_pkg::S_RST) |-> !r_reg.cpu_rst_n)
    else $error("processor reset high during release delay");

  a_rtc_stays_on: assert property (r_reg.loaded |-> r_reg.rtc_en)
    else $error("rtc rail off after start");

  // The mirror copy is taken once, on the first enabled edge after reset.
  a_off_slot_load: assert property (
    (clk_en && !r_reg.loaded) |=> (r_reg.off_slot == $past(reg_on_slot)))
    else $error("off slots did not load from on slots");

  a_off_wr_gated: assert property (
    (clk_en && r_reg.loaded && !r_reg.sys_on && bus_write) |=> (r_reg.off_slot == $past(r_reg.off_slot)))
    else $error("off slot changed while system off");

  a_sleep_up_seq: assert property (
    (clk_en && r_reg.st == ros_pkg::S_IDLE && r_reg.loaded && req_valid
      && req_kind == ros_pkg::K_SLEEP_RUN) |=> (r_reg.st == ros_pkg::S_UP))
    else $error("sleep to run skipped the sequencer");

  a_up_end_now: assert property (
    (clk_en && r_reg.st == ros_pkg::S_UP && r_reg.kind != ros_pkg::K_DIS_RUN
      && (r_reg.work & on_above) == '0) |=> (r_reg.st == ros_pkg::S_IDLE && r_reg.done))
    else $error("power-up did not end at last rail");

  a_stby_dn_skip: assert property (
    (clk_en && r_reg.st == ros_pkg::S_IDLE && r_reg.loaded && req_valid
      && req_kind == ros_pkg::K_RUN_STBY && (r_reg.rail_en & ~req_target) == '0)
    |=> (r_reg.st == ros_pkg::S_IDLE && r_reg.done && r_reg.status[ros_pkg::BIT_PWRDN]))
    else $error("run to standby without drops did not finish at once");

  a_sleep_zero_now: assert property (
    (clk_en && r_reg.st == ros_pkg::S_IDLE && r_reg.loaded && req_valid && off_all_zero
      && req_kind == ros_pkg::K_RUN_SLEEP) |=> (r_reg.done && r_reg.status[ros_pkg::BIT_PWRDN]))
    else $error("run to sleep with zero slots did not finish at once");

  a_busy_idle: assert property ((r_reg.st != ros_pkg::S_IDLE) |-> r_reg.busy)
    else $error("sequencer busy flag low while stepping");

endmodule

// *** verif/ros_cpu_model.sv ***
// Processor model that runs only once the sequencer lets go of its reset.
`timescale 1ns/10ps
module ros_cpu_model (
  input  wire logic clk_sys,
  input  wire logic processor_reset_out_n,
  output logic      cpu_on
);
  // Held in reset.
  // Slot rewrites are only legal while this is high, so the bench checks it before rewriting.
  always_ff @(posedge clk_sys) begin
    cpu_on <= processor_reset_out_n;
  end
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the regulator on/off sequencer.
`timescale 1ns/10ps
module testbench;
  localparam int SF = 4, SS = 8, SD = 8, RB = 4;
  logic             clk_sys = 0, reset_n = 0, seq_step_speed = 0, req_valid = 0;
  logic             bus_write = 0, bus_read = 0, rd_pend = 0, prev_rst = 0, clk_en = 1;
  logic             rtc_supply_rail, processor_reset_out_n, seq_busy, trans_done, irq, cpu_on;
  logic [6:0][2:0]  reg_on_slot = '0, off_slot = '0;
  logic [2:0]       reset_release_delay_sel = '0, req_kind = '0;
  logic [6:0]       req_target = '0, rail_en, prev_en = '0;
  logic [7:0]       bus_addr = '0;
  logic [31:0]      bus_wdata = '0, bus_rdata;
  int               up_t[7], dn_t[7], rst_t, cyc, ndone, fail_count, checked, mx, d;
  logic [6:0]       rail_q[$];
  logic [31:0]      rd_q[$];

  always #12.5 clk_sys = ~clk_sys;

  ros_sequencer #(.STEP_FAST_CYC(SF), .STEP_SLOW_CYC(SS), .STEP_DOWN_CYC(SD),
    .RST_BASE_CYC(RB)) ros_sequencer_i (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .reg_on_slot(reg_on_slot), .reset_release_delay_sel(reset_release_delay_sel),
    .seq_step_speed(seq_step_speed), .req_valid(req_valid), .req_kind(req_kind),
    .req_target(req_target), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata), .rail_en(rail_en),
    .rtc_supply_rail(rtc_supply_rail), .processor_reset_out_n(processor_reset_out_n),
    .seq_busy(seq_busy), .trans_done(trans_done), .irq(irq));
  ros_cpu_model ros_cpu_model_i (.clk_sys(clk_sys),
    .processor_reset_out_n(processor_reset_out_n), .cpu_on(cpu_on));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d failures %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // The monitor stamps every rail edge so ordering is judged after the transition.
  always @(posedge clk_sys) begin
    cyc++;
    if (rd_pend) chk("rdata", bus_rdata, rd_q.pop_front());
    rd_pend <= bus_read;
    if (trans_done === 1'b1) begin
      ndone++;
      chk("rail_en", {25'h0, rail_en}, {25'h0, rail_q.pop_front()});
    end
    for (int i = 0; i < 7; i++) begin
      if (rail_en[i] === 1'b1 && prev_en[i] !== 1'b1) up_t[i] = cyc;
      if (rail_en[i] === 1'b0 && prev_en[i] === 1'b1) dn_t[i] = cyc;
    end
    if (processor_reset_out_n === 1'b1 && prev_rst !== 1'b1) rst_t = cyc;
    prev_en <= rail_en;
    prev_rst <= processor_reset_out_n;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= v;
    bus_write <= 1'b1;
    @(posedge clk_sys);
    bus_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_read <= 1'b1;
    rd_q.push_back(e);
    @(posedge clk_sys);
    bus_read <= 1'b0;
  endtask

  task automatic req(input logic [2:0] k, input logic [6:0] t);
    int n0;
    n0 = ndone;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_kind <= k;
    req_target <= t;
    rail_q.push_back(t);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    for (int w = 0; w < 20000 && ndone == n0; w++) @(posedge clk_sys);
    chk("done", ndone - n0, 1);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic ord(input logic [6:0][2:0] s, input int t[7], input int step, input bit up);
    for (int i = 0; i < 7; i++) begin
      for (int j = 0; j < 7; j++) begin
        if (s[i] < s[j]) chk("order", ((up ? t[j] - t[i] : t[i] - t[j]) >= step), 1);
        else if (s[i] == s[j]) chk("same", (t[i] == t[j]), 1);
      end
    end
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys);
    fail_count++;
    end_sim();
  end

  initial begin
    void'($urandom(6001));
    for (int i = 0; i < 7; i++) begin
      reg_on_slot[i] = 3'($urandom_range(7));
      off_slot[i] = 3'($urandom_range(7, 1));
    end
    reset_release_delay_sel = 3'($urandom_range(7));
    seq_step_speed = 1'($urandom_range(1));
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("rtc", rtc_supply_rail, 1);
    chk("rails_off", {25'h0, rail_en}, 0);
    chk("cpu_rst", processor_reset_out_n, 0);
    chk("busy", seq_busy, 0);
    // A write while the system is off must not stick.
    wr(ros_pkg::ADDR_OFF_BASE, {29'h0, ~reg_on_slot[0]});
    for (int i = 0; i < 7; i++) rd(8'(4 * i), {29'h0, reg_on_slot[i]});
    rd(8'h30, 32'h0);
    // A write while the clock enable is low must be frozen out.
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(ros_pkg::ADDR_MASK, 32'h3);
    clk_en <= 1'b1;
    rd(ros_pkg::ADDR_MASK, 32'h0);
    $display("test 1 reset done");

    req(3'h0, 7'h7F);
    ord(reg_on_slot, up_t, seq_step_speed ? SS : SF, 1);
    mx = 0;
    foreach (up_t[i]) if (up_t[i] > mx) mx = up_t[i];
    d = RB * int'(ros_pkg::RST_MULT[reset_release_delay_sel]);
    chk("rst_low", (rst_t > mx), 1);
    chk("rst_gap", (rst_t - mx >= d && rst_t - mx <= d + 12), 1);
    rd(ros_pkg::ADDR_STATUS, 32'h0);
    #1;
    chk("cpu_on", cpu_on, 1);
    $display("test 2 power up done");

    for (int i = 0; i < 7; i++) wr(8'(4 * i), {29'h0, off_slot[i]});
    wr(ros_pkg::ADDR_MASK, 32'h3);
    req(3'h4, 7'h00);
    ord(off_slot, dn_t, SD, 0);
    rd(ros_pkg::ADDR_STATUS, 32'h2);
    #1;
    chk("irq_set", irq, 1);
    wr(ros_pkg::ADDR_STATUS, 32'h2);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq_clr", irq, 0);
    $display("test 3 power down done");

    req(3'h2, 7'h7F);
    rd(ros_pkg::ADDR_STATUS, 32'h1);
    wr(ros_pkg::ADDR_STATUS, 32'h1);
    req(3'h3, 7'h7F);
    rd(ros_pkg::ADDR_STATUS, 32'h2);
    wr(ros_pkg::ADDR_STATUS, 32'h2);
    req(3'h1, 7'h7F);
    rd(ros_pkg::ADDR_STATUS, 32'h1);
    wr(ros_pkg::ADDR_STATUS, 32'h1);
    $display("test 4 mode changes done");

    for (int i = 0; i < 7; i++) wr(8'(4 * i), 32'h0);
    req(3'h4, 7'h00);
    ord('0, dn_t, SD, 0);
    rd(ros_pkg::ADDR_STATUS, 32'h2);
    repeat (3) @(posedge clk_sys);
    $display("test 5 bypass done");
    end_sim();
  end
endmodule
